// [common/dcd_pkg.sv]
// constants and types shared by the cascaded dma control block
// assumes byte-wide i/o register accesses with 16-bit i/o addresses
package dcd_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CH_PER_CTL = 4;
  localparam int unsigned SVC_W = 9; // {channel[2:0], mode[5:0]}

  // ****************************************
  // i/o offsets, first controller
  // ****************************************
  localparam logic [15:0] CTL1_CMD_OFS = 16'h0008; // write command, read status
  localparam logic [15:0] CTL1_SREQ_OFS = 16'h0009;
  localparam logic [15:0] CTL1_SMASK_OFS = 16'h000a;
  localparam logic [15:0] CTL1_MODE_OFS = 16'h000b;
  localparam logic [15:0] CTL1_AMASK_OFS = 16'h000f;

  // ****************************************
  // i/o offsets, second controller
  // ****************************************
  localparam logic [15:0] CTL2_CMD_OFS = 16'h00d0;
  localparam logic [15:0] CTL2_SREQ_OFS = 16'h00d2;
  localparam logic [15:0] CTL2_SMASK_OFS = 16'h00d4;
  localparam logic [15:0] CTL2_MODE_OFS = 16'h00d6;
  localparam logic [15:0] CTL2_AMASK_OFS = 16'h00de;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CMD_DACK_HI_BIT = 7;
  localparam int unsigned CMD_DREQ_LO_BIT = 6;
  localparam int unsigned CMD_ROTATE_BIT = 4;
  localparam int unsigned CMD_DISABLE_BIT = 2;
  localparam int unsigned SET_BIT = 2; // request and single mask set/clear bit
  localparam int unsigned MODE_AUTO_BIT = 2; // within the stored 6-bit mode
  localparam int unsigned MODE_DIR_BIT = 3;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] SREQ_RST = 8'h00;
  localparam logic [7:0] TC_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ****************************************
  // mode encodings
  // ****************************************
  typedef enum logic [1:0] {
    XM_DEMAND = 2'b00,
    XM_SINGLE = 2'b01,
    XM_BLOCK = 2'b10,
    XM_CASCADE = 2'b11
  } dcd_xmode_t;

  typedef enum logic [1:0] {
    XT_VERIFY = 2'b00,
    XT_WRITE = 2'b01,
    XT_READ = 2'b10,
    XT_ILLEGAL = 2'b11
  } dcd_xtype_t;

endpackage : dcd_pkg

// [verilog/dcd_dma_ctrl.sv]
// request gating, arbitration and programming registers of two cascaded
// four-channel dma controllers, plus the service queue toward the engine
// assumes dcd_pkg is compiled first; tc pulses come from same-clock logic
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// service queue
// ****************************************
module dcd_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] wr_nxt = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
  wire [AW-1:0] rd_nxt = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;

  // honest full and empty from the fill count
  assign in_ready = (cnt_q != (AW + 1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_nxt;
      if (pop) rd_q <= rd_nxt;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : dcd_fifo

// ****************************************
// controller pair
// ****************************************
module dcd_dma_ctrl #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic master_clear,
  // host i/o port
  input wire logic pci_wr,
  input wire logic pci_rd,
  input wire logic [15:0] pci_addr,
  input wire logic [7:0] pci_wdata,
  output logic pci_ack,
  // isa i/o port
  input wire logic isa_wr,
  input wire logic isa_rd,
  input wire logic [15:0] isa_addr,
  input wire logic [7:0] isa_wdata,
  output logic isa_ack,
  // read data for either port
  output logic [7:0] rd_data,
  // peripheral pins
  input wire logic [7:0] dreq,
  output logic [7:0] dack,
  // transfer engine
  input wire logic [7:0] tc_in,
  output logic svc_valid,
  input wire logic svc_ready,
  output logic [dcd_pkg::SVC_W-1:0] svc_data
);

  // ****************************************
  // access selection and decode
  // ****************************************
  logic [7:0] cmd_q [2];
  logic [5:0] mode_q [8];
  logic [7:0] sreq_q;
  logic [7:0] mask_q;
  logic [7:0] tc_q;
  logic [1:0] last_q [2];
  logic [7:0] inflight_q;
  logic [7:0] dreq_s1_q;
  logic [7:0] dreq_s2_q;
  logic [7:0] dack_q;
  logic [7:0] rdata_q;
  logic pci_ack_q;
  logic isa_ack_q;

  // host wins a same-cycle clash; the isa side holds its strobe until acked
  wire pci_acc = pci_wr | pci_rd;
  wire isa_acc = (isa_wr | isa_rd) & ~pci_acc & ~isa_ack_q; // strobe held over ack not retaken
  wire [15:0] a_addr = pci_acc ? pci_addr : isa_addr;
  wire [7:0] a_wdata = pci_acc ? pci_wdata : isa_wdata;
  wire a_wr = pci_acc ? pci_wr : (isa_acc & isa_wr);
  wire a_rd = pci_acc ? pci_rd : (isa_acc & isa_rd);
  wire [1:0] a_sel = a_wdata[1:0];

  // per-controller strobes; command writes only from the host side
  wire [1:0] wr_cmd;
  wire [1:0] wr_sreq;
  wire [1:0] wr_smask;
  wire [1:0] wr_mode;
  wire [1:0] wr_amask;
  wire [1:0] rd_stat;
  wire [1:0] rd_amask;
  assign wr_cmd = {2{a_wr & pci_acc}}
    & {a_addr == dcd_pkg::CTL2_CMD_OFS, a_addr == dcd_pkg::CTL1_CMD_OFS};
  assign wr_sreq = {2{a_wr}}
    & {a_addr == dcd_pkg::CTL2_SREQ_OFS, a_addr == dcd_pkg::CTL1_SREQ_OFS};
  assign wr_smask = {2{a_wr}}
    & {a_addr == dcd_pkg::CTL2_SMASK_OFS, a_addr == dcd_pkg::CTL1_SMASK_OFS};
  assign wr_mode = {2{a_wr}}
    & {a_addr == dcd_pkg::CTL2_MODE_OFS, a_addr == dcd_pkg::CTL1_MODE_OFS};
  assign wr_amask = {2{a_wr}}
    & {a_addr == dcd_pkg::CTL2_AMASK_OFS, a_addr == dcd_pkg::CTL1_AMASK_OFS};
  assign rd_stat = {2{a_rd}}
    & {a_addr == dcd_pkg::CTL2_CMD_OFS, a_addr == dcd_pkg::CTL1_CMD_OFS};
  assign rd_amask = {2{a_rd}}
    & {a_addr == dcd_pkg::CTL2_AMASK_OFS, a_addr == dcd_pkg::CTL1_AMASK_OFS};

  // ****************************************
  // request conditioning
  // ****************************************
  wire [1:0] dack_hi = {cmd_q[1][dcd_pkg::CMD_DACK_HI_BIT], cmd_q[0][dcd_pkg::CMD_DACK_HI_BIT]};
  wire [1:0] dreq_lo = {cmd_q[1][dcd_pkg::CMD_DREQ_LO_BIT], cmd_q[0][dcd_pkg::CMD_DREQ_LO_BIT]};
  wire [1:0] rotate = {cmd_q[1][dcd_pkg::CMD_ROTATE_BIT], cmd_q[0][dcd_pkg::CMD_ROTATE_BIT]};
  wire [1:0] grp_off = {cmd_q[1][dcd_pkg::CMD_DISABLE_BIT], cmd_q[0][dcd_pkg::CMD_DISABLE_BIT]};

  // channel four has no pin; its line is the first controller's cascade
  wire [7:0] hw_req = (dreq_s2_q ^ {{4{dreq_lo[1]}}, {4{dreq_lo[0]}}}) & 8'hef;
  wire [7:0] mask_eff = mask_q | {4'h0, {4{mask_q[4]}}};
  wire [7:0] pending = (hw_req & ~mask_eff) | sreq_q;
  wire [7:0] group_on = {{4{~grp_off[1]}}, {4{~grp_off[0] & ~grp_off[1]}}};
  wire [7:0] elig = pending & ~inflight_q & group_on;

  // ****************************************
  // arbitration
  // ****************************************
  // returns {found, index}; fixed puts channel 0 first, rotating starts after last
  function automatic logic [2:0] dcd_pick(input logic [3:0] r, input logic rot,
                                          input logic [1:0] last);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int k = 3; k >= 0; k--) begin
      idx = rot ? 2'(last + 2'(k) + 2'h1) : 2'(k);
      if (r[idx]) res = {1'b1, idx};
    end
    return res;
  endfunction : dcd_pick

  wire casc_req = |elig[3:0];
  wire [2:0] pick1 = dcd_pick(elig[3:0], rotate[0], last_q[0]);
  wire [2:0] pick2 = dcd_pick({elig[7:5], casc_req}, rotate[1], last_q[1]); // four only relays
  wire grant = pick2[2];
  wire grant_casc = grant & (pick2[1:0] == 2'h0);
  wire [2:0] grant_ch = grant_casc ? {1'b0, pick1[1:0]} : {1'b1, pick2[1:0]};
  wire [5:0] grant_mode = mode_q[grant_ch];

  // cascade channels carry no meaningful type
  wire grant_is_casc = (grant_mode[5:4] == dcd_pkg::XM_CASCADE);
  wire [5:0] svc_mode = grant_is_casc ? {grant_mode[5:2], 2'h0} : grant_mode;

  // ****************************************
  // service queue
  // ****************************************
  logic fifo_in_ready;
  wire push = grant & fifo_in_ready;
  wire pop = svc_valid & svc_ready;
  wire [2:0] head_ch = svc_data[dcd_pkg::SVC_W-1 -: 3];

  dcd_fifo #(
    .W(dcd_pkg::SVC_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .flush(master_clear),
    .in_valid(grant),
    .in_ready(fifo_in_ready),
    .in_data({grant_ch, svc_mode}),
    .out_valid(svc_valid),
    .out_ready(svc_ready),
    .out_data(svc_data)
  );

  // ****************************************
  // next register values
  // ****************************************
  logic [5:0] mode_d [8];
  logic [7:0] sreq_d;
  logic [7:0] mask_d;
  logic [7:0] tc_d;
  logic [7:0] inflight_d;
  logic [7:0] dack_d;
  logic [1:0] last_d [2];
  logic [7:0] rdata_d;

  // per-channel programming, terminal count and queue tracking
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      automatic int c = i / 4;
      automatic logic hit = (a_sel == 2'(i % 4));
      automatic logic active = svc_valid & (head_ch == 3'(i));
      mode_d[i] = (wr_mode[c] & hit) ? a_wdata[7:2] : mode_q[i];
      sreq_d[i] = (wr_sreq[c] & hit) ? a_wdata[dcd_pkg::SET_BIT] : sreq_q[i];
      if (tc_in[i]) sreq_d[i] = 1'b0;
      mask_d[i] = mask_q[i];
      if (wr_smask[c] & hit) mask_d[i] = a_wdata[dcd_pkg::SET_BIT];
      if (wr_amask[c]) mask_d[i] = a_wdata[i % 4];
      if (tc_in[i] & ~mode_q[i][dcd_pkg::MODE_AUTO_BIT]) mask_d[i] = 1'b1;
      tc_d[i] = (tc_q[i] & ~rd_stat[c]) | tc_in[i];
      inflight_d[i] = inflight_q[i];
      if (pop & (head_ch == 3'(i))) inflight_d[i] = 1'b0;
      if (push & (grant_ch == 3'(i))) inflight_d[i] = 1'b1;
      dack_d[i] = (i == 4) ? ~dack_hi[1] : (active ~^ dack_hi[c]);
    end
  end

  // rotation pointers follow each grant the queue accepts
  always_comb begin
    last_d[0] = last_q[0];
    last_d[1] = last_q[1];
    if (push) begin
      last_d[1] = pick2[1:0];
      if (grant_casc) last_d[0] = pick1[1:0];
    end
  end

  // read data: status, mask image, or zero for unmapped offsets
  always_comb begin
    rdata_d = dcd_pkg::UNMAPPED_RD;
    if (rd_stat[0]) rdata_d = {pending[3:0], tc_q[3:0]};
    if (rd_stat[1]) rdata_d = {pending[7:4], tc_q[7:4]};
    if (rd_amask[0]) rdata_d = {4'h0, mask_q[3:0]};
    if (rd_amask[1]) rdata_d = {4'h0, mask_q[7:4]};
  end

  // ****************************************
  // registers
  // ****************************************
  // request pin synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dreq_s1_q <= 8'h00;
      dreq_s2_q <= 8'h00;
    end else begin
      dreq_s1_q <= dreq;
      dreq_s2_q <= dreq_s1_q;
    end
  end

  // programming state; master clear acts like reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= '{dcd_pkg::CMD_RST, dcd_pkg::CMD_RST};
      mode_q <= '{default: dcd_pkg::MODE_RST};
      sreq_q <= dcd_pkg::SREQ_RST;
      mask_q <= dcd_pkg::MASK_RST;
      tc_q <= dcd_pkg::TC_RST;
    end else if (master_clear) begin
      cmd_q <= '{dcd_pkg::CMD_RST, dcd_pkg::CMD_RST};
      mode_q <= '{default: dcd_pkg::MODE_RST};
      sreq_q <= dcd_pkg::SREQ_RST;
      mask_q <= dcd_pkg::MASK_RST;
      tc_q <= dcd_pkg::TC_RST;
    end else begin
      if (wr_cmd[0]) cmd_q[0] <= a_wdata;
      if (wr_cmd[1]) cmd_q[1] <= a_wdata;
      mode_q <= mode_d;
      sreq_q <= sreq_d;
      mask_q <= mask_d;
      tc_q <= tc_d;
    end
  end

  // arbitration and acknowledge state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_q <= '{2'h3, 2'h3};
      inflight_q <= 8'h00;
      dack_q <= 8'hff;
    end else if (master_clear) begin
      last_q <= '{2'h3, 2'h3};
      inflight_q <= 8'h00;
      dack_q <= 8'hff;
    end else begin
      last_q <= last_d;
      inflight_q <= inflight_d;
      dack_q <= dack_d;
    end
  end

  // port answers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= dcd_pkg::RDATA_RST;
      pci_ack_q <= 1'b0;
      isa_ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      pci_ack_q <= pci_acc;
      isa_ack_q <= isa_acc;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dack = dack_q;
  assign rd_data = rdata_q;
  assign pci_ack = pci_ack_q;
  assign isa_ack = isa_ack_q;

endmodule : dcd_dma_ctrl

`default_nettype wire

// [verification/dcd_props.sv]
// port assertions for the cascaded dma control block
// assumes a bind onto dcd_dma_ctrl, single clock domain
`timescale 1ns/1ps
`default_nettype none
module dcd_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic master_clear,
  // i/o ports
  input wire logic pci_wr,
  input wire logic pci_rd,
  input wire logic pci_ack,
  input wire logic isa_wr,
  input wire logic isa_rd,
  input wire logic isa_ack,
  input wire logic [7:0] rd_data,
  // service queue
  input wire logic svc_valid,
  input wire logic svc_ready,
  input wire logic [dcd_pkg::SVC_W-1:0] svc_data
);
  // ****************************************
  // port relations
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  wire logic host_s = pci_wr | pci_rd;
  wire logic isa_s = isa_wr | isa_rd;
  property p_hack;
    host_s |=> pci_ack;
  endproperty
  property p_hsrc;
    pci_ack |-> $past(host_s);
  endproperty
  property p_iref;
    isa_s && host_s |=> !isa_ack;
  endproperty
  property p_isrc;
    isa_ack |-> $past(isa_s) && !$past(host_s);
  endproperty
  property p_rdz;
    !pci_rd && !isa_rd |=> rd_data == 8'h00;
  endproperty
  property p_hold;
    svc_valid && !svc_ready && !master_clear |=> svc_valid && $stable(svc_data);
  endproperty
  property p_casc;
    svc_valid && svc_data[5:4] == 2'b11 |-> svc_data[1:0] == 2'b00;
  endproperty
  property p_no4;
    svc_valid |-> svc_data[8:6] != 3'h4;
  endproperty
  property p_clr;
    master_clear |=> !svc_valid [*2];
  endproperty
  property p_ione;
    isa_ack |=> !isa_ack;
  endproperty
  a_hack: assert property (p_hack) else $error("host ack missing");
  a_hsrc: assert property (p_hsrc) else $error("stray host ack");
  a_iref: assert property (p_iref) else $error("isa ack under host");
  a_isrc: assert property (p_isrc) else $error("stray isa ack");
  a_rdz: assert property (p_rdz) else $error("read data not zero");
  a_hold: assert property (p_hold) else $error("queue head moved");
  a_casc: assert property (p_casc) else $error("cascade type kept");
  a_no4: assert property (p_no4) else $error("cascade channel queued");
  a_clr: assert property (p_clr) else $error("queue not flushed");
  a_ione: assert property (p_ione) else $error("held isa strobe taken twice");
  c_pop: cover property (svc_valid && svc_ready);
  c_isa: cover property (isa_ack);
  c_stat: cover property (pci_ack && rd_data != 8'h00);
endmodule : dcd_props
bind dcd_dma_ctrl dcd_props u_props (.clk, .arst_n, .master_clear, .pci_wr, .pci_rd,
  .pci_ack, .isa_wr, .isa_rd, .isa_ack, .rd_data, .svc_valid, .svc_ready, .svc_data);
`default_nettype wire

// [verification/dcd_periph.sv]
// isa peripherals raising requests and taking acknowledges
// assumes the bench sets request sense and acknowledge level
`timescale 1ns/1ps
`default_nettype none
module dcd_periph (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bench side
  input wire logic [7:0] raise,
  input wire logic sense_lo,
  input wire logic ack_hi,
  output logic [7:0] served,
  // device pins
  input wire logic [7:0] dack,
  output logic [7:0] dreq
);
  logic [7:0] want_q;
  logic pat_q;
  wire logic [7:0] got = (ack_hi ? dack : ~dack) & 8'hef;
  // request held until acknowledged; served cleared by a new raise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      want_q <= 8'h00;
      served <= 8'h00;
      pat_q <= 1'b0;
    end else begin
      want_q <= (want_q | raise) & ~got;
      served <= (|raise) ? 8'h00 : served | got;
      pat_q <= ~pat_q;
    end
  end
  // no pin behind channel four, so a changing level there
  assign dreq = ((sense_lo ? ~want_q : want_q) & 8'hef) | {3'h0, pat_q, 4'h0};
endmodule : dcd_periph
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the cascaded dma control block
// assumes dcd_pkg, the design and the peripheral model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, arst_n = 1'b0, master_clear = 1'b0, pci_wr = 1'b0, pci_rd = 1'b0;
  logic isa_wr = 1'b0, isa_rd = 1'b0, svc_ready = 1'b0, sense_lo = 1'b0, ack_hi = 1'b0;
  logic [15:0] pci_addr = 16'h0000, isa_addr = 16'h0000;
  logic [7:0] pci_wdata = 8'h00, isa_wdata = 8'h00, tc_in = 8'h00, raise = 8'h00;
  logic [7:0] rd_data, dreq, dack, served;
  logic pci_ack, isa_ack, svc_valid;
  logic [8:0] svc_data;
  int error_cnt = 0;
  int checks_done = 0;
  always #25 clk = ~clk;
  dcd_dma_ctrl #(.FIFO_DEPTH(4)) u_dut (.clk, .arst_n, .master_clear, .pci_wr, .pci_rd,
    .pci_addr, .pci_wdata, .pci_ack, .isa_wr, .isa_rd, .isa_addr, .isa_wdata, .isa_ack,
    .rd_data, .dreq, .dack, .tc_in, .svc_valid, .svc_ready, .svc_data);
  dcd_periph u_per (.clk, .arst_n, .raise, .sense_lo, .ack_hi, .served, .dack, .dreq);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic hw(input logic [15:0] a, input logic [7:0] d);
    pci_wr <= 1'b1;
    pci_addr <= a;
    pci_wdata <= d;
    @(posedge clk);
    pci_wr <= 1'b0;
    @(posedge clk);
  endtask : hw
  task automatic hr(input logic [15:0] a, input logic [7:0] e);
    pci_rd <= 1'b1;
    pci_addr <= a;
    @(posedge clk);
    pci_rd <= 1'b0;
    #1 chk({1'b0, rd_data}, {1'b0, e});
    @(posedge clk);
  endtask : hr
  task automatic iw(input logic [15:0] a, input logic [7:0] d);
    int n;
    isa_wr <= 1'b1;
    isa_addr <= a;
    isa_wdata <= d;
    for (n = 0; isa_ack !== 1'b1; n++) begin
      if (n > 50) begin
        chk(9'h000, 9'h001);
        test_done();
      end
      @(posedge clk);
    end
    isa_wr <= 1'b0;
    @(posedge clk);
  endtask : iw
  task automatic pulse(input logic [7:0] r, input logic [7:0] t);
    raise <= r;
    tc_in <= t;
    @(posedge clk);
    raise <= 8'h00;
    tc_in <= 8'h00;
    @(posedge clk);
  endtask : pulse
  // wait for a queue head, compare it, let the peripheral see it, pop
  task automatic gs(input logic [2:0] c, input logic [5:0] m);
    int n;
    for (n = 0; svc_valid !== 1'b1; n++) begin
      if (n > 60) begin
        chk(9'h000, 9'h001);
        test_done();
      end
      @(posedge clk);
    end
    chk(svc_data, {c, m});
    repeat (4) @(posedge clk);
    svc_ready <= 1'b1;
    @(posedge clk);
    svc_ready <= 1'b0;
    @(posedge clk);
  endtask : gs
  task automatic ns;
    repeat (10) @(posedge clk);
    chk({8'h00, svc_valid}, 9'h000);
  endtask : ns
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    hr(16'h0008, 8'h00);
    hr(16'h00d0, 8'h00);
    hr(16'h000f, 8'h0f);
    hr(16'h00de, 8'h0f);
    chk({1'b0, dack}, 9'h0ff);
    $display("reset test done");
  endtask : t_reset
  task automatic t_tc;
    for (int a = 0; a < 2; a++) begin
      hw(16'h00d4, 8'h01);
      hw(16'h00d6, {3'h2, a[0], 4'h5});
      pulse(8'h20, 8'h00);
      gs(3'h5, {3'h2, a[0], 2'h1});
      chk({1'b0, served}, 9'h020);
      pulse(8'h00, 8'h20);
      hr(16'h00de, a[0] ? 8'h0d : 8'h0f);
      hr(16'h00d0, 8'h02);
    end
    $display("terminal count test done");
  endtask : t_tc
  task automatic t_mode;
    hw(16'h00d4, 8'h02);
    for (int i = 0; i < 4; i++) begin
      hw(16'h00d6, {i[1:0], i[0], i[1], i[1:0], 2'h2});
      pulse(8'h40, 8'h00);
      gs(3'h6, {i[1:0], i[0], i[1], (i == 3) ? 2'h0 : i[1:0]});
    end
    $display("mode test done");
  endtask : t_mode
  task automatic t_soft;
    hw(16'h00de, 8'h0f);
    pulse(8'h40, 8'h00);
    ns();
    hw(16'h00d6, 8'h8b);
    hw(16'h00d2, 8'h07);
    hr(16'h00d0, 8'h80);
    pulse(8'h00, 8'h80);
    gs(3'h7, 6'h22);
    hr(16'h00d0, 8'h08);
    hw(16'h00de, 8'h00);
    gs(3'h6, 6'h3c);
    $display("soft request test done");
  endtask : t_soft
  task automatic t_prio;
    pulse(8'he0, 8'h00);
    gs(3'h5, 6'h15);
    gs(3'h6, 6'h3c);
    gs(3'h7, 6'h22);
    hw(16'h00d0, 8'h10);
    pulse(8'h40, 8'h00);
    gs(3'h6, 6'h3c);
    pulse(8'ha0, 8'h00);
    gs(3'h7, 6'h22);
    gs(3'h5, 6'h15);
    $display("priority test done");
  endtask : t_prio
  task automatic t_pol;
    hw(16'h00de, 8'h0f);
    hw(16'h00d0, 8'hc0);
    hw(16'h0008, 8'hc0);
    sense_lo <= 1'b1;
    ack_hi <= 1'b1;
    repeat (4) @(posedge clk);
    chk({6'h00, dack[7:5]}, 9'h000);
    hw(16'h00de, 8'h00);
    pulse(8'h20, 8'h00);
    gs(3'h5, 6'h15);
    chk({1'b0, served}, 9'h020);
    master_clear <= 1'b1;
    @(posedge clk);
    master_clear <= 1'b0;
    sense_lo <= 1'b0;
    ack_hi <= 1'b0;
    hr(16'h000f, 8'h0f);
    hr(16'h00d0, 8'h00);
    chk({1'b0, dack}, 9'h0ff);
    $display("polarity test done");
  endtask : t_pol
  task automatic t_dis;
    hw(16'h000f, 8'h00);
    pulse(8'h01, 8'h00);
    ns();
    hw(16'h00d4, 8'h00);
    gs(3'h0, 6'h00);
    hw(16'h00d0, 8'h04);
    pulse(8'h02, 8'h00);
    ns();
    hw(16'h00d0, 8'h00);
    gs(3'h1, 6'h00);
    hw(16'h000a, 8'h07);
    fork
      iw(16'h000a, 8'h03);
      hr(16'h0055, 8'h00);
    join
    iw(16'h0008, 8'h04);
    pulse(8'h08, 8'h00);
    gs(3'h3, 6'h00);
    $display("disable test done");
  endtask : t_dis
  task automatic t_fill;
    hw(16'h00de, 8'h00);
    hw(16'h000f, 8'h00);
    pulse(8'hef, 8'h00);
    repeat (20) @(posedge clk);
    chk({8'h00, svc_valid}, 9'h001);
    gs(3'h0, 6'h00);
    gs(3'h1, 6'h00);
    gs(3'h2, 6'h00);
    gs(3'h3, 6'h00);
    gs(3'h5, 6'h00);
    gs(3'h6, 6'h00);
    gs(3'h7, 6'h00);
    ns();
    $display("queue test done");
  endtask : t_fill
  // reset, then every scenario in turn
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tc();
    t_mode();
    t_soft();
    t_prio();
    t_pol();
    t_dis();
    t_fill();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
